// file: ptc_transport_cfg.sv
// Purpose: Capability chain and common configuration registers of a paravirtual PCI function
// Assumes: One dword request per cycle on each port; answers one cycle later
// Notes:   Only the common configuration structure is decoded on the BAR port
// Rules for this block and for the driver that uses it
// [R01] 64-bit fields split into independent halves
// [R02] Vendor capabilities locate structures, little-endian, read-only
// [R03] Capability starts with 0x09 and next pointer
// [R04] Byte count covers header plus extra fields
// [R05] Structure type codes one to five
// [R06] Several per type, listed most preferred first
// [R07] Region index zero to five selects BAR
// [R08] Capability gives structure start and length
// [R09] Driver skips reserved type or region
// [R10] Driver tolerates oversized counts and lengths
// [R11] Driver never writes locating capabilities
// [R12] Offered features shown through 32-bit window
// [R13] Accepted features written through own window
// [R14] Config-change and per-queue vectors writable
// [R15] Maximum queue count read-only
// [R16] Writing zero to status resets device
// [R17] Generation changes on noticeable config change
// [R18] Per-queue fields follow queue pointer
// [R19] Ring size shows maximum, zero means absent
// [R20] Run flag gates queue processing
// [R21] Read-only doorbell index per queue
// [R22] Three 64-bit ring addresses held
// [R23] Status reads zero once reset completes
// [R24] All run flags zero after reset
`timescale 1ns/1ps

module ptc_transport_cfg #(
  parameter logic [63:0] OFFERED_FEATURES = 64'h0000_0001_0000_0000,
  parameter logic [15:0] RING_MAX         = 16'h0100,
  parameter logic [7:0]  LAST_NEXT_LINK   = 8'h00
) (
  // Clock and reset
  input  wire logic                      sys_clk,
  input  wire logic                      rst,
  // Configuration-space access
  input  wire logic                      cfg_req_valid,
  input  wire ptc_pkg::ptc_req_type      cfg_req,
  output logic [31:0]                    cfg_rdata,
  output logic                           cfg_ack,
  // Common configuration BAR access
  input  wire logic                      bar_req_valid,
  input  wire ptc_pkg::ptc_req_type      bar_req,
  output logic [31:0]                    bar_rdata,
  output logic                           bar_ack,
  // Device core side
  input  wire logic                      dev_cfg_changed,
  input  wire logic                      dev_cfg_read,
  output logic [ptc_pkg::PTC_NQ-1:0]     queue_run,
  output logic [7:0]                     lifecycle_status,
  output logic [7:0]                     config_change_counter,
  output logic [63:0]                    accepted_features
);
  import ptc_pkg::*;

  ptc_state_type st_r;
  ptc_state_type st_nxt;

  function automatic logic [31:0] merge32(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] wd,
                                          input logic [1:0] be);
    return 16'(merge32({16'h0000, old}, {16'h0000, wd}, {2'b00, be}));
  endfunction

  // Capability chain contents; every field read-only (see [R02]) (see [R11])
  function automatic logic [31:0] cap_word(input logic [7:0] addr);
    logic [31:0] w;
    logic [7:0]  base;
    logic [7:0]  nxt;
    logic [7:0]  len;
    logic [7:0]  typ;
    w = 32'h0000_0000;
    for (int i = 0; i < PTC_CAP_COUNT; i++) begin
      base = PTC_CAP_BASE + 8'(i) * PTC_CAP_STRIDE;
      nxt  = (i == PTC_CAP_COUNT - 1) ? LAST_NEXT_LINK : base + PTC_CAP_STRIDE;
      typ  = 8'(i + 1); // see [R05] see [R06]
      // Notify and access capabilities carry one extra dword
      len  = (typ == PTC_NOTIFY_STRUCT_TYPE || typ == PTC_CFG_ACCESS_STRUCT_TYPE) ?
             PTC_CAP_LEN_EXTRA : PTC_CAP_LEN_PLAIN; // see [R04]
      for (int d = 0; d < PTC_CAP_DWORDS; d++) begin
        if (addr[7:2] == 6'((base >> 2) + 8'(d))) begin
          unique case (d)
            0: w = {typ, len, nxt, PTC_CAP_ID}; // see [R03] see [R02]
            1: w = {24'h00_0000, PTC_CAP_REGION[i]}; // see [R07]
            2: w = PTC_CAP_START[i]; // see [R08]
            3: w = PTC_CAP_LENGTH[i]; // see [R08]
            4: w = (typ == PTC_NOTIFY_STRUCT_TYPE) ? PTC_NOTIFY_MULT : 32'h0000_0000;
            default: w = 32'h0000_0000;
          endcase
        end
      end
    end
    return w;
  endfunction

  function automatic ptc_queue_type queue_default();
    ptc_queue_type q;
    q      = '0;
    q.size = RING_MAX; // see [R19]
    q.vec  = PTC_NO_VECTOR;
    q.run  = 1'b0; // see [R24]
    return q;
  endfunction

  logic             qv;
  logic [PTC_QW-1:0] qi;
  ptc_queue_type    qs;
  logic [3:0]       widx;

  always_comb begin
    qv     = st_r.qsel < 16'(PTC_NQ);
    qi     = st_r.qsel[PTC_QW-1:0];
    qs     = st_r.q[qi];
    widx   = bar_req.addr[5:2];
    st_nxt = st_r;
    st_nxt.cfg_ack = 1'b0;
    st_nxt.bar_ack = 1'b0;

    // Flag then bump keeps an 8-bit counter from aliasing on wrap; a new change wins
    if (dev_cfg_read && st_r.chg_pend) begin
      st_nxt.gen      = st_r.gen + 8'h01; // see [R17]
      st_nxt.chg_pend = 1'b0;
    end
    if (dev_cfg_changed) begin
      st_nxt.chg_pend = 1'b1; // see [R17]
    end

    // Configuration space: writes are dropped, unmapped reads give zero
    if (cfg_req_valid) begin
      st_nxt.cfg_ack   = 1'b1;
      st_nxt.cfg_rdata = cfg_req.we ? 32'h0000_0000 : cap_word(cfg_req.addr[7:0]); // see [R11]
    end

    if (bar_req_valid) begin
      st_nxt.bar_ack   = 1'b1;
      st_nxt.bar_rdata = 32'h0000_0000;
      if (bar_req.addr[11:6] != 6'h00) begin
        st_nxt.bar_rdata = 32'h0000_0000;
      end else if (!bar_req.we) begin
        unique case (widx)
          PTC_W_OFFER_WIN:  st_nxt.bar_rdata = st_r.offer_win;
          PTC_W_OFFER_BITS: begin
            // Windows beyond bit 63 show zero
            if (st_r.offer_win == 32'h0000_0000) begin
              st_nxt.bar_rdata = OFFERED_FEATURES[31:0]; // see [R12]
            end else if (st_r.offer_win == 32'h0000_0001) begin
              st_nxt.bar_rdata = OFFERED_FEATURES[63:32]; // see [R12]
            end
          end
          PTC_W_ACC_WIN:    st_nxt.bar_rdata = st_r.acc_win;
          PTC_W_ACC_BITS: begin
            if (st_r.acc_win == 32'h0000_0000) begin
              st_nxt.bar_rdata = st_r.acc_bits[31:0]; // see [R13]
            end else if (st_r.acc_win == 32'h0000_0001) begin
              st_nxt.bar_rdata = st_r.acc_bits[63:32]; // see [R13]
            end
          end
          PTC_W_VEC_NQ:     st_nxt.bar_rdata = {16'(PTC_NQ), st_r.cfg_vec}; // see [R15]
          PTC_W_STATUS:     st_nxt.bar_rdata = {st_r.qsel, st_r.gen, st_r.status};
          PTC_W_SIZE_VEC: begin
            if (qv) begin
              st_nxt.bar_rdata = {qs.vec, qs.size}; // see [R18] see [R19]
            end
          end
          PTC_W_RUN_DB: begin
            // Doorbell index is the queue number, in multiplier units
            if (qv) begin
              st_nxt.bar_rdata = {st_r.qsel, 15'h0000, qs.run}; // see [R21] see [R20]
            end
          end
          4'h8:    st_nxt.bar_rdata = qv ? qs.desc[31:0]  : 32'h0000_0000; // see [R22]
          4'h9:    st_nxt.bar_rdata = qv ? qs.desc[63:32] : 32'h0000_0000;
          4'hA:    st_nxt.bar_rdata = qv ? qs.drv[31:0]   : 32'h0000_0000;
          4'hB:    st_nxt.bar_rdata = qv ? qs.drv[63:32]  : 32'h0000_0000;
          4'hC:    st_nxt.bar_rdata = qv ? qs.dev[31:0]   : 32'h0000_0000;
          4'hD:    st_nxt.bar_rdata = qv ? qs.dev[63:32]  : 32'h0000_0000;
          default: st_nxt.bar_rdata = 32'h0000_0000;
        endcase
      end else begin
        unique case (widx)
          PTC_W_OFFER_WIN: st_nxt.offer_win = merge32(st_r.offer_win, bar_req.wdata, bar_req.be);
          PTC_W_ACC_WIN:   st_nxt.acc_win = merge32(st_r.acc_win, bar_req.wdata, bar_req.be);
          PTC_W_ACC_BITS: begin
            // Bits never offered are dropped, so reads show only valid bits
            if (st_r.acc_win == 32'h0000_0000) begin
              st_nxt.acc_bits[31:0] = merge32(st_r.acc_bits[31:0], bar_req.wdata, bar_req.be)
                                      & OFFERED_FEATURES[31:0]; // see [R13]
            end else if (st_r.acc_win == 32'h0000_0001) begin
              st_nxt.acc_bits[63:32] = merge32(st_r.acc_bits[63:32], bar_req.wdata, bar_req.be)
                                       & OFFERED_FEATURES[63:32]; // see [R13]
            end
          end
          PTC_W_VEC_NQ: begin
            st_nxt.cfg_vec = merge16(st_r.cfg_vec, bar_req.wdata[15:0], bar_req.be[1:0]); // see [R14]
          end
          PTC_W_STATUS: begin
            if (bar_req.be[0]) begin
              st_nxt.status = bar_req.wdata[7:0]; // see [R16]
              if (bar_req.wdata[7:0] == 8'h00) begin
                // Reset completes in this cycle, so the next read already sees zero
                for (int i = 0; i < PTC_NQ; i++) begin
                  st_nxt.q[i] = queue_default(); // see [R16] see [R24]
                end
                st_nxt.offer_win = 32'h0000_0000;
                st_nxt.acc_win   = 32'h0000_0000;
                st_nxt.acc_bits  = 64'h0000_0000_0000_0000;
                st_nxt.cfg_vec   = PTC_NO_VECTOR;
                st_nxt.qsel      = 16'h0000;
                st_nxt.status    = 8'h00; // see [R23]
              end
            end
            st_nxt.qsel = merge16(st_nxt.qsel, bar_req.wdata[31:16], bar_req.be[3:2]); // see [R18]
          end
          PTC_W_SIZE_VEC: begin
            if (qv) begin
              st_nxt.q[qi].size = merge16(qs.size, bar_req.wdata[15:0], bar_req.be[1:0]); // see [R19]
              st_nxt.q[qi].vec = merge16(qs.vec, bar_req.wdata[31:16], bar_req.be[3:2]); // see [R14]
            end
          end
          PTC_W_RUN_DB: begin
            if (qv && bar_req.be[0]) begin
              st_nxt.q[qi].run = bar_req.wdata[0]; // see [R20]
            end
          end
          4'h8: if (qv) st_nxt.q[qi].desc[31:0] = merge32(qs.desc[31:0], bar_req.wdata, bar_req.be); // see [R01]
          4'h9: if (qv) st_nxt.q[qi].desc[63:32] = merge32(qs.desc[63:32], bar_req.wdata, bar_req.be);
          4'hA: if (qv) st_nxt.q[qi].drv[31:0] = merge32(qs.drv[31:0], bar_req.wdata, bar_req.be); // see [R22]
          4'hB: if (qv) st_nxt.q[qi].drv[63:32] = merge32(qs.drv[63:32], bar_req.wdata, bar_req.be);
          4'hC: if (qv) st_nxt.q[qi].dev[31:0] = merge32(qs.dev[31:0], bar_req.wdata, bar_req.be);
          4'hD: if (qv) st_nxt.q[qi].dev[63:32] = merge32(qs.dev[63:32], bar_req.wdata, bar_req.be);
          default: st_nxt.bar_rdata = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
      for (int i = 0; i < PTC_NQ; i++) begin
        st_r.q[i].size <= RING_MAX; // see [R19]
        st_r.q[i].vec  <= PTC_NO_VECTOR;
      end
      st_r.cfg_vec <= PTC_NO_VECTOR;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Core uses the run flags to stop fetching from disabled queues
  for (genvar g = 0; g < PTC_NQ; g++) begin : g_run
    assign queue_run[g] = st_r.q[g].run; // see [R20]
  end

  assign cfg_rdata             = st_r.cfg_rdata;
  assign cfg_ack               = st_r.cfg_ack;
  assign bar_rdata             = st_r.bar_rdata;
  assign bar_ack               = st_r.bar_ack;
  assign lifecycle_status      = st_r.status;
  assign config_change_counter = st_r.gen;
  assign accepted_features     = st_r.acc_bits;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  logic bar_rd;
  logic status_zero_wr;
  assign bar_rd         = bar_req_valid && !bar_req.we && bar_req.addr[11:6] == 6'h00;
  assign status_zero_wr = bar_req_valid && bar_req.we && bar_req.addr[11:2] == 10'h005
                          && bar_req.be[0] && bar_req.wdata[7:0] == 8'h00;

  sequence s_zero_written;
    status_zero_wr;
  endsequence

  sequence s_reset_done;
    st_r.status == 8'h00 && queue_run == '0 ##1 !bar_req_valid [*1];
  endsequence

  a_reset_clears_all: assert property (s_zero_written |=> st_r.status == 8'h00 && queue_run == '0) // see [R16]
    else $error("status zero write did not reset device");
  a_reset_reads_zero: assert property (s_zero_written ##2 bar_rd && widx == PTC_W_STATUS
                                       |=> bar_rdata[7:0] == 8'h00) // see [R23]
    else $error("status not read back as zero after reset");
  a_cap_id_byte: assert property (cfg_req_valid && !cfg_req.we && cfg_req.addr[7:0] == PTC_CAP_BASE
                                  |=> cfg_ack && cfg_rdata[7:0] == 8'h09
                                      && cfg_rdata[31:24] == PTC_COMMON_STRUCT_TYPE) // see [R03]
    else $error("first capability header wrong");
  a_cap_chain_next: assert property (cfg_req_valid && !cfg_req.we && cfg_req.addr[7:0] == 8'h54
                                     |=> cfg_rdata[15:8] == 8'h68
                                         && cfg_rdata[31:24] == PTC_NOTIFY_STRUCT_TYPE) // see [R05]
    else $error("second capability link or type wrong");
  a_offer_window: assert property (bar_rd && widx == PTC_W_OFFER_BITS && st_r.offer_win == 32'h1
                                   |=> bar_rdata == OFFERED_FEATURES[63:32]) // see [R12]
    else $error("offered feature high window wrong");
  a_gen_bump: assert property (dev_cfg_read && st_r.chg_pend
                               |=> config_change_counter == $past(config_change_counter) + 8'h01) // see [R17]
    else $error("generation did not advance");
  a_half_indep: assert property (bar_req_valid && bar_req.we && widx == PTC_W_DESC_LO && qv
                                 |=> st_r.q[$past(qi)].desc[63:32] == $past(qs.desc[63:32])) // see [R01]
    else $error("low half write disturbed high half");
  a_absent_queue: assert property (bar_rd && widx == PTC_W_SIZE_VEC && !qv
                                   |=> bar_ack && bar_rdata == 32'h0000_0000) // see [R19]
    else $error("absent queue did not read zero");
  a_ack_timing: assert property (bar_req_valid |=> bar_ack ##1 (bar_ack == $past(bar_req_valid))) // bar_ack one cycle after each request
    else $error("bar answer not one cycle after request");
  a_dev_top_hi: assert property (bar_rd && widx == PTC_W_DEV_HI && qv
                                 |=> bar_rdata == $past(qs.dev[63:32])) // see [R22]
    else $error("device area high half readback wrong");

endmodule

// file: ptc_pkg.sv
// Purpose: Shared constants and carriers for the PCI transport configuration block
// Assumes: Config-space and BAR accesses arrive as one dword request per cycle
// Notes:   Capability chain sits at a fixed base in configuration space
package ptc_pkg;

  // Queue count and its index width
  localparam int PTC_NQ = 4;
  localparam int PTC_QW = 2;

  // Capability chain
  localparam logic [7:0]  PTC_CAP_ID        = 8'h09;
  localparam logic [7:0]  PTC_CAP_BASE      = 8'h40;
  localparam logic [7:0]  PTC_CAP_STRIDE    = 8'h14;
  localparam int          PTC_CAP_COUNT     = 5;
  localparam int          PTC_CAP_DWORDS    = 5;
  localparam logic [7:0]  PTC_CAP_LEN_PLAIN = 8'h10;
  localparam logic [7:0]  PTC_CAP_LEN_EXTRA = 8'h14;
  localparam logic [7:0]  PTC_REGION_MAX    = 8'h05;
  localparam logic [7:0]  PTC_BAR_CFG_BASE  = 8'h10;

  // Structure type codes; anything outside 1..5 is reserved
  localparam logic [7:0] PTC_COMMON_STRUCT_TYPE     = 8'h01;
  localparam logic [7:0] PTC_NOTIFY_STRUCT_TYPE     = 8'h02;
  localparam logic [7:0] PTC_IRQ_STATUS_STRUCT_TYPE = 8'h03;
  localparam logic [7:0] PTC_DEVICE_STRUCT_TYPE     = 8'h04;
  localparam logic [7:0] PTC_CFG_ACCESS_STRUCT_TYPE = 8'h05;

  // Structure placement, in order of preference
  localparam logic [31:0] PTC_NOTIFY_MULT = 32'h0000_0004;
  localparam logic [31:0] PTC_NOTIFY_LEN  = 32'(PTC_NQ) * PTC_NOTIFY_MULT + 32'h0000_0002;
  localparam logic [7:0]  PTC_CAP_REGION [PTC_CAP_COUNT] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [31:0] PTC_CAP_START  [PTC_CAP_COUNT] =
    '{32'h0000_0000, 32'h0000_1000, 32'h0000_2000, 32'h0000_3000, 32'h0000_0000};
  localparam logic [31:0] PTC_CAP_LENGTH [PTC_CAP_COUNT] =
    '{32'h0000_0038, PTC_NOTIFY_LEN, 32'h0000_0001, 32'h0000_0100, 32'h0000_0000};

  // Common configuration word indices (byte offset / 4)
  localparam logic [3:0] PTC_W_OFFER_WIN  = 4'h0;
  localparam logic [3:0] PTC_W_OFFER_BITS = 4'h1;
  localparam logic [3:0] PTC_W_ACC_WIN    = 4'h2;
  localparam logic [3:0] PTC_W_ACC_BITS   = 4'h3;
  localparam logic [3:0] PTC_W_VEC_NQ     = 4'h4;
  localparam logic [3:0] PTC_W_STATUS     = 4'h5;
  localparam logic [3:0] PTC_W_SIZE_VEC   = 4'h6;
  localparam logic [3:0] PTC_W_RUN_DB     = 4'h7;
  localparam logic [3:0] PTC_W_DESC_LO    = 4'h8;
  localparam logic [3:0] PTC_W_DEV_HI     = 4'hD;

  // Values after reset
  localparam logic [15:0] PTC_NO_VECTOR = 16'hFFFF;

  // Access request carrier
  typedef struct packed {
    logic        we;
    logic [11:0] addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } ptc_req_type;

  typedef struct packed {
    logic [15:0] size;
    logic [15:0] vec;
    logic        run;
    logic [63:0] desc;
    logic [63:0] drv;
    logic [63:0] dev;
  } ptc_queue_type;

  typedef struct packed {
    ptc_queue_type [PTC_NQ-1:0] q;
    logic [31:0] offer_win;
    logic [31:0] acc_win;
    logic [63:0] acc_bits;
    logic [15:0] cfg_vec;
    logic [7:0]  status;
    logic [7:0]  gen;
    logic        chg_pend;
    logic [15:0] qsel;
    logic [31:0] cfg_rdata;
    logic [31:0] bar_rdata;
    logic        cfg_ack;
    logic        bar_ack;
  } ptc_state_type;

endpackage

// file: ptc_host_model.sv
// Purpose: Host driver model issuing dword accesses on the config and BAR ports
// Assumes: One request at a time; the answer comes one cycle after the request is taken
// Notes:   Released request lines show the inverse of their last value
`timescale 1ns/1ps

module ptc_host_model (
  // Clock
  input  wire logic             sys_clk,
  // Answers
  input  wire logic             cfg_ack,
  input  wire logic [31:0]      cfg_rdata,
  input  wire logic             bar_ack,
  input  wire logic [31:0]      bar_rdata,
  // Requests
  output logic                  cfg_req_valid,
  output ptc_pkg::ptc_req_type  cfg_req,
  output logic                  bar_req_valid,
  output ptc_pkg::ptc_req_type  bar_req
);
  import ptc_pkg::*;

  initial begin
    cfg_req_valid = 1'b0;
    bar_req_valid = 1'b0;
    cfg_req = '0;
    bar_req = '0;
  end

  // Config space is only ever read; writes go to the BAR alone
  task automatic xfer(input logic on_bar, input ptc_req_type r, output logic [31:0] rd);
    int n = 0;
    @(posedge sys_clk);
    #2;
    if (on_bar) begin
      bar_req = r;
      bar_req_valid = 1'b1;
    end else begin
      cfg_req = r;
      cfg_req_valid = 1'b1;
    end
    @(posedge sys_clk);
    #2;
    cfg_req_valid = 1'b0;
    bar_req_valid = 1'b0;
    cfg_req = ~cfg_req;
    bar_req = ~bar_req;
    while (((on_bar ? bar_ack : cfg_ack) !== 1'b1) && n < 4) begin
      @(posedge sys_clk);
      #2;
      n++;
    end
    rd = on_bar ? bar_rdata : cfg_rdata;
    // A missing answer must not pass for data
    if (n == 4) rd = 32'hXXXX_XXXX;
  endtask
endmodule

// file: tb_top.sv
// Purpose: Self-checking bench for the transport capability and common config block
// Assumes: Host model drives both request ports; core pulses come from here
// Notes:   Expectations come from a small reference model of the registers
`timescale 1ns/1ps

module tb_top;
  import ptc_pkg::*;
  localparam logic [63:0] OFFER = 64'h0000_0003_8000_00F1;
  localparam logic [15:0] RMAX  = 16'h0040;
  logic sys_clk, rst, dev_cfg_changed, dev_cfg_read;
  logic cfg_req_valid, bar_req_valid, cfg_ack, bar_ack;
  ptc_req_type cfg_req, bar_req;
  logic [31:0] cfg_rdata, bar_rdata, rd, rv, hd;
  logic [PTC_NQ-1:0] queue_run;
  logic [7:0] lifecycle_status, config_change_counter;
  logic [63:0] accepted_features, m_acc;
  logic [31:0] m_sv [PTC_NQ];
  logic [31:0] m_ad [PTC_NQ][6];
  int num_errors, num_checks, seed, i, k, w;

  ptc_transport_cfg #(.OFFERED_FEATURES(OFFER), .RING_MAX(RMAX)) uut (
    .sys_clk(sys_clk), .rst(rst), .cfg_req_valid(cfg_req_valid), .cfg_req(cfg_req),
    .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack), .bar_req_valid(bar_req_valid),
    .bar_req(bar_req), .bar_rdata(bar_rdata), .bar_ack(bar_ack),
    .dev_cfg_changed(dev_cfg_changed), .dev_cfg_read(dev_cfg_read), .queue_run(queue_run),
    .lifecycle_status(lifecycle_status), .config_change_counter(config_change_counter),
    .accepted_features(accepted_features));

  ptc_host_model host (
    .sys_clk(sys_clk), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata), .bar_ack(bar_ack),
    .bar_rdata(bar_rdata), .cfg_req_valid(cfg_req_valid), .cfg_req(cfg_req),
    .bar_req_valid(bar_req_valid), .bar_req(bar_req));

  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [3:0] wd, input logic [3:0] be, input logic [31:0] d);
    logic [31:0] x;
    host.xfer(1'b1, '{1'b1, {6'h00, wd, 2'b00}, be, d}, x);
  endtask

  task automatic rdb(input logic [3:0] wd, output logic [31:0] d);
    host.xfer(1'b1, '{1'b0, {6'h00, wd, 2'b00}, 4'hF, 32'h0}, d);
  endtask

  task automatic pulse(input logic chg, input logic rdp);
    @(posedge sys_clk);
    #2;
    dev_cfg_changed = chg;
    dev_cfg_read = rdp;
    @(posedge sys_clk);
    #2;
    dev_cfg_changed = 1'b0;
    dev_cfg_read = 1'b0;
    @(posedge sys_clk);
    #2;
  endtask

  task automatic give_verdict();
    $display("Checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  initial begin
    #2000000;
    num_errors++;
    give_verdict();
  end

  initial begin
    seed = 4913;
    rst = 1'b1;
    dev_cfg_changed = 1'b0;
    dev_cfg_read = 1'b0;
    m_acc = '0;
    repeat (6) @(posedge sys_clk);
    #2;
    rst = 1'b0;
    check("queue_run", queue_run, 0);
    check("config_change_counter", config_change_counter, 0);
    // Walk by next pointer, so an oversized byte count is harmless
    w = PTC_CAP_BASE;
    for (i = 0; i < PTC_CAP_COUNT; i++) begin
      host.xfer(1'b0, '{1'b0, 12'(w), 4'hF, 32'h0}, hd);
      check("cap_id_code", hd[7:0], PTC_CAP_ID);
      check("cap_structure_type", hd[31:24], i + 1);
      check("cap_byte_count", hd[23:16], (i == 1 || i == 4) ? 8'h14 : 8'h10);
      check("cap_next_link", hd[15:8], (i == 4) ? 0 : w + PTC_CAP_STRIDE);
      for (k = 1; k < 5; k++) begin
        host.xfer(1'b0, '{1'b0, 12'(w + 4 * k), 4'hF, 32'h0}, rd);
        rv = (k == 1) ? 32'(PTC_CAP_REGION[i]) : (k == 2) ? PTC_CAP_START[i] :
             (k == 3) ? PTC_CAP_LENGTH[i] : ((i == 1) ? PTC_NOTIFY_MULT : 32'h0);
        check("cap_field", rd, rv);
      end
      w = hd[15:8];
    end
    for (i = 0; i < 3; i++) begin
      wr(PTC_W_OFFER_WIN, 4'hF, i);
      rdb(PTC_W_OFFER_BITS, rd);
      check("offered_feature_bits", rd, (i < 2) ? OFFER[i*32+:32] : 0);
      rv = $random(seed);
      wr(PTC_W_ACC_WIN, 4'hF, i);
      wr(PTC_W_ACC_BITS, 4'hF, rv);
      if (i < 2) m_acc[i*32+:32] = rv & OFFER[i*32+:32];
      rdb(PTC_W_ACC_BITS, rd);
      check("accepted_feature_bits", rd, (i < 2) ? m_acc[i*32+:32] : 0);
    end
    check("accepted_features", accepted_features, m_acc);
    rv = $random(seed);
    wr(PTC_W_VEC_NQ, 4'hF, rv);
    rdb(PTC_W_VEC_NQ, rd);
    check("max_queue_count", rd, {16'(PTC_NQ), rv[15:0]});
    for (i = 0; i <= PTC_NQ; i++) begin
      wr(PTC_W_STATUS, 4'hC, {16'(i), 16'h0});
      rdb(PTC_W_SIZE_VEC, rd);
      check("ring_entry_count", rd, (i < PTC_NQ) ? {PTC_NO_VECTOR, RMAX} : 0);
      rdb(PTC_W_RUN_DB, rd);
      check("ring_doorbell_index", rd, (i < PTC_NQ) ? {16'(i), 16'h0} : 0);
      rv = $random(seed);
      wr(PTC_W_SIZE_VEC, 4'hF, rv);
      if (i < PTC_NQ) m_sv[i] = rv;
      // Each half is its own access
      for (k = 0; k < 6; k++) begin
        rv = $random(seed);
        wr(PTC_W_DESC_LO + 4'(k), 4'hF, rv);
        if (i < PTC_NQ) m_ad[i][k] = rv;
      end
    end
    for (i = 0; i < PTC_NQ; i++) begin
      wr(PTC_W_STATUS, 4'hC, {16'(i), 16'h0});
      rdb(PTC_W_SIZE_VEC, rd);
      check("ring_vector_num", rd, m_sv[i]);
      for (k = 0; k < 6; k++) begin
        rdb(PTC_W_DESC_LO + 4'(k), rd);
        check("ring_area_addr", rd, m_ad[i][k]);
      end
    end
    wr(PTC_W_STATUS, 4'hC, 32'h0002_0000);
    wr(PTC_W_RUN_DB, 4'hF, 32'h0000_0001);
    check("queue_run", queue_run, 4'b0100);
    rdb(PTC_W_RUN_DB, rd);
    check("ring_run_flag", rd, 32'h0002_0001);
    pulse(1'b0, 1'b1);
    check("config_change_counter", config_change_counter, 0);
    pulse(1'b1, 1'b0);
    pulse(1'b0, 1'b1);
    check("config_change_counter", config_change_counter, 1);
    wr(PTC_W_STATUS, 4'h1, 32'h0000_000F);
    check("lifecycle_status", lifecycle_status, 8'h0F);
    wr(PTC_W_STATUS, 4'h1, 32'h0);
    rdb(PTC_W_STATUS, rd);
    check("lifecycle_status", rd, 32'h0000_0100);
    check("queue_run", queue_run, 0);
    check("accepted_features", accepted_features, 0);
    rdb(PTC_W_SIZE_VEC, rd);
    check("ring_entry_count", rd, {PTC_NO_VECTOR, RMAX});
    give_verdict();
  end
endmodule
